/* core/stxcs_pkg.sv */
// Purpose: constants for the transmit channel status register bank
// Assumes: 8-bit register port with register index addressing
// Notes:   reset values are those of the programmed channel status fields
package stxcs_pkg;
  localparam logic [7:0] STXCS_ADDR_CATEGORY  = 8'h20;
  localparam logic [7:0] STXCS_ADDR_SRC_CHAN  = 8'h21;
  localparam logic [7:0] STXCS_ADDR_SAMPLE_RATE_FIELD_ACC  = 8'h22;
  localparam logic [7:0] STXCS_ADDR_WL_ORIG   = 8'h23;
  localparam logic [7:0] STXCS_RST_CATEGORY   = 8'h00;
  localparam logic [7:0] STXCS_RST_SRC_CHAN   = 8'h00;
  localparam logic [7:0] STXCS_RST_SAMPLE_RATE_FIELD_ACC   = 8'h31;
  localparam logic [7:0] STXCS_RST_WL_ORIG    = 8'h0B;
  localparam logic [1:0] STXCS_SRC_RECEIVER   = 2'h0;
  localparam logic [7:0] STXCS_FRAMES_PER_BLK = 8'hC0;
  localparam logic [7:0] STXCS_PROG_BITS      = 8'h28;
  localparam logic [7:0] STXCS_CS_LO          = 8'h08;
  // field positions inside the register bytes
  localparam int         STXCS_FLD_SOURCE_NUMBER_FIELD     = 0;
  localparam int         STXCS_FLD_CHAN1      = 4;
  localparam int         STXCS_FLD_CHAN2      = 6;
  localparam int         STXCS_FLD_RATE       = 0;
  localparam int         STXCS_FLD_ACCURACY   = 4;
  localparam int         STXCS_FLD_MAXLEN     = 0;
  localparam int         STXCS_FLD_WORDLEN    = 1;
  localparam int         STXCS_FLD_ORIGRATE   = 4;
  // field positions inside the channel status block
  localparam int         STXCS_CSB_CATEGORY   = 8;
  localparam int         STXCS_CSB_SOURCE_NUMBER_FIELD     = 16;
  localparam int         STXCS_CSB_CHAN1      = 20;
  localparam int         STXCS_CSB_CHAN2      = 22;
  localparam int         STXCS_CSB_RATE       = 24;
  localparam int         STXCS_CSB_ACCURACY   = 28;
  localparam int         STXCS_CSB_MAXLEN     = 32;
  localparam int         STXCS_CSB_WORDLEN    = 33;
  localparam int         STXCS_CSB_ORIGRATE   = 36;
endpackage

/* core/stxcs_bank.sv */
// Purpose: transmit channel status register bank and bit server
// Assumes: frame builder asks for a bit index and sub-frame each sub-frame
// Notes:   bits 0..7 come from elsewhere in via cs_low_bits
//
// Operation
// - category byte on status bits 15:8
// - subframe one channel number on 21:20
// - subframe two channel number on 23:22
// - sample rate on 27:24, reset 0001
// - clock accuracy on 29:28, reset 11
// - one bit per sub-frame, 192-frame blocks
// - both sub-frames same except channel number
// - receiver source retransmits unless overwrite set
`timescale 1ns/10ps
module stxcs_bank
  import stxcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] transmit_source_select,
  input  wire logic       status_overwrite_bit,
  input  wire logic [7:0] cs_low_bits,
  input  wire logic       cs_req,
  input  wire logic [7:0] cs_index,
  input  wire logic       cs_subframe,
  input  wire logic       rx_cs_bit,
  output logic            cs_bit_q,
  output logic            cs_valid_q
);

  // one-hot register select: bit 0 is 0x20 up to bit 3 for 0x23
  typedef logic [3:0] stxcs_sel_t;

  // programmed fields, one flop group per field
  logic [7:0]  category_field_q;
  logic [7:0]  category_field_d;
  logic [3:0]  source_number_field_q;
  logic [3:0]  source_number_field_d;
  logic [1:0]  subframe1_channel_field_q;
  logic [1:0]  subframe1_channel_field_d;
  logic [1:0]  subframe2_channel_field_q;
  logic [1:0]  subframe2_channel_field_d;
  logic [3:0]  sample_rate_field_q;
  logic [3:0]  sample_rate_field_d;
  logic [1:0]  clock_accuracy_field_q;
  logic [1:0]  clock_accuracy_field_d;
  logic        max_length_flag_q;
  logic        max_length_flag_d;
  logic [2:0]  word_length_code_q;
  logic [2:0]  word_length_code_d;
  logic [3:0]  original_rate_field_q;
  logic [3:0]  original_rate_field_d;

  // bit server state
  logic        cs_bit_d;
  logic        cs_valid_d;

  // decode and status image helpers
  stxcs_sel_t  wr_sel;
  stxcs_sel_t  rd_sel;
  logic [39:0] status_image;
  logic        use_receiver;

  // address decode shared by the write and read paths
  function automatic stxcs_sel_t decode_addr(input logic [7:0] addr);
    stxcs_sel_t sel;
    sel = 4'h0;
    if (addr == STXCS_ADDR_CATEGORY) begin
      sel = 4'h1;
    end else if (addr == STXCS_ADDR_SRC_CHAN) begin
      sel = 4'h2;
    end else if (addr == STXCS_ADDR_SAMPLE_RATE_FIELD_ACC) begin
      sel = 4'h4;
    end else if (addr == STXCS_ADDR_WL_ORIG) begin
      sel = 4'h8;
    end
    return sel;
  endfunction

  // a sub-frame shows only its own channel number; the other slot says not used
  function automatic logic [1:0] chan_slot(input logic [1:0] code,
                                           input logic       own);
    logic [1:0] slot;
    slot = 2'h0;
    if (own) begin
      slot = code;
    end
    return slot;
  endfunction

  // 40-bit status image for one sub-frame; bits 31:30 stay zero
  function automatic logic [39:0] build_word(input logic sub);
    logic [39:0] w;
    w                          = 40'h00_0000_0000;
    w[7:0]                     = cs_low_bits;
    w[STXCS_CSB_CATEGORY +: 8] = category_field_q;
    w[STXCS_CSB_SOURCE_NUMBER_FIELD +: 4]   = source_number_field_q;
    w[STXCS_CSB_CHAN1 +: 2]    = chan_slot(subframe1_channel_field_q, !sub);
    w[STXCS_CSB_CHAN2 +: 2]    = chan_slot(subframe2_channel_field_q, sub);
    w[STXCS_CSB_RATE +: 4]     = sample_rate_field_q;
    w[STXCS_CSB_ACCURACY +: 2] = clock_accuracy_field_q;
    w[STXCS_CSB_MAXLEN]        = max_length_flag_q;
    w[STXCS_CSB_WORDLEN +: 3]  = word_length_code_q;
    w[STXCS_CSB_ORIGRATE +: 4] = original_rate_field_q;
    return w;
  endfunction

  // only the first 40 bits carry content; later bits of the block send zero
  function automatic logic programmed_bit(input logic [39:0] image,
                                          input logic [7:0]  index);
    logic bit_val;
    bit_val = 1'b0;
    if (index < STXCS_PROG_BITS) begin
      bit_val = image[index[5:0]];
    end
    return bit_val;
  endfunction

  // write side: a strobe to an unmapped index changes nothing
  always_comb begin
    wr_sel                    = 4'h0;
    category_field_d          = category_field_q;
    source_number_field_d     = source_number_field_q;
    subframe1_channel_field_d = subframe1_channel_field_q;
    subframe2_channel_field_d = subframe2_channel_field_q;
    sample_rate_field_d       = sample_rate_field_q;
    clock_accuracy_field_d    = clock_accuracy_field_q;
    max_length_flag_d         = max_length_flag_q;
    word_length_code_d        = word_length_code_q;
    original_rate_field_d     = original_rate_field_q;
    if (reg_wr) begin
      wr_sel = decode_addr(reg_addr);
    end
    if (wr_sel[0]) begin
      category_field_d = reg_wdata;
    end
    if (wr_sel[1]) begin
      source_number_field_d     = reg_wdata[STXCS_FLD_SOURCE_NUMBER_FIELD +: 4];
      subframe1_channel_field_d = reg_wdata[STXCS_FLD_CHAN1 +: 2];
      subframe2_channel_field_d = reg_wdata[STXCS_FLD_CHAN2 +: 2];
    end
    if (wr_sel[2]) begin
      sample_rate_field_d    = reg_wdata[STXCS_FLD_RATE +: 4];
      clock_accuracy_field_d = reg_wdata[STXCS_FLD_ACCURACY +: 2];
    end
    if (wr_sel[3]) begin
      max_length_flag_d     = reg_wdata[STXCS_FLD_MAXLEN];
      word_length_code_d    = reg_wdata[STXCS_FLD_WORDLEN +: 3];
      original_rate_field_d = reg_wdata[STXCS_FLD_ORIGRATE +: 4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      category_field_q          <= STXCS_RST_CATEGORY;
      source_number_field_q     <= STXCS_RST_SRC_CHAN[STXCS_FLD_SOURCE_NUMBER_FIELD +: 4];
      subframe1_channel_field_q <= STXCS_RST_SRC_CHAN[STXCS_FLD_CHAN1 +: 2];
      subframe2_channel_field_q <= STXCS_RST_SRC_CHAN[STXCS_FLD_CHAN2 +: 2];
      sample_rate_field_q       <= STXCS_RST_SAMPLE_RATE_FIELD_ACC[STXCS_FLD_RATE +: 4];
      clock_accuracy_field_q    <= STXCS_RST_SAMPLE_RATE_FIELD_ACC[STXCS_FLD_ACCURACY +: 2];
      max_length_flag_q         <= STXCS_RST_WL_ORIG[STXCS_FLD_MAXLEN];
      word_length_code_q        <= STXCS_RST_WL_ORIG[STXCS_FLD_WORDLEN +: 3];
      original_rate_field_q     <= STXCS_RST_WL_ORIG[STXCS_FLD_ORIGRATE +: 4];
    end else begin
      category_field_q          <= category_field_d;
      source_number_field_q     <= source_number_field_d;
      subframe1_channel_field_q <= subframe1_channel_field_d;
      subframe2_channel_field_q <= subframe2_channel_field_d;
      sample_rate_field_q       <= sample_rate_field_d;
      clock_accuracy_field_q    <= clock_accuracy_field_d;
      max_length_flag_q         <= max_length_flag_d;
      word_length_code_q        <= word_length_code_d;
      original_rate_field_q     <= original_rate_field_d;
    end
  end

  // read side: combinational, unmapped indexes and spare bits read zero
  always_comb begin
    rd_sel    = decode_addr(reg_addr);
    reg_rdata = 8'h00;
    if (rd_sel[0]) begin
      reg_rdata = category_field_q;
    end
    if (rd_sel[1]) begin
      reg_rdata[STXCS_FLD_SOURCE_NUMBER_FIELD +: 4] = source_number_field_q;
      reg_rdata[STXCS_FLD_CHAN1 +: 2]  = subframe1_channel_field_q;
      reg_rdata[STXCS_FLD_CHAN2 +: 2]  = subframe2_channel_field_q;
    end
    if (rd_sel[2]) begin
      reg_rdata[STXCS_FLD_RATE +: 4]     = sample_rate_field_q;
      reg_rdata[STXCS_FLD_ACCURACY +: 2] = clock_accuracy_field_q;
    end
    if (rd_sel[3]) begin
      reg_rdata[STXCS_FLD_MAXLEN]        = max_length_flag_q;
      reg_rdata[STXCS_FLD_WORDLEN +: 3]  = word_length_code_q;
      reg_rdata[STXCS_FLD_ORIGRATE +: 4] = original_rate_field_q;
    end
  end

  // bit server: the answer holds between requests so a slow reader still sees it
  always_comb begin
    status_image = build_word(cs_subframe);
    use_receiver = (transmit_source_select == STXCS_SRC_RECEIVER) && !status_overwrite_bit;
    cs_valid_d   = cs_req;
    cs_bit_d     = cs_bit_q;
    if (cs_req) begin
      if (use_receiver) begin
        cs_bit_d = rx_cs_bit;
      end else begin
        cs_bit_d = programmed_bit(status_image, cs_index);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_bit_q   <= 1'b0;
      cs_valid_q <= 1'b0;
    end else begin
      cs_bit_q   <= cs_bit_d;
      cs_valid_q <= cs_valid_d;
    end
  end
endmodule // stxcs_bank

/* bench/stxcs_properties.sv */
// Purpose: port assertions for the status bank
// Assumes: bound by the bench
// Notes: pg marks the programmed path
`timescale 1ns/10ps
module stxcs_props (input wire logic clk_sys, reset, reg_wr, status_overwrite_bit, cs_req,
  cs_subframe, rx_cs_bit, cs_bit_q, cs_valid_q, input wire logic [1:0] transmit_source_select,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, cs_low_bits, cs_index);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire pg = transmit_source_select != 2'h0 || status_overwrite_bit;
  wire ch = cs_req && pg && cs_subframe && cs_index[7:1] == 7'h0A;
  sequence wr_cat; reg_wr && reg_addr == 8'h20 ##1 reg_addr == 8'h20; endsequence
  AST_ANS: assert property (cs_req |=> cs_valid_q) else $error("ans");
  AST_PLS: assert property (!cs_req |=> !cs_valid_q) else $error("pls");
  AST_HLD: assert property (!cs_req |=> $stable(cs_bit_q)) else $error("hld");
  AST_CAT: assert property (wr_cat |-> reg_rdata == $past(reg_wdata)) else $error("cat");
  AST_P40: assert property (cs_req && pg && cs_index >= 8'h28 |=> !cs_bit_q) else $error("p");
  AST_GAP: assert property (cs_req && pg && cs_index[7:1] == 7'h0F |=> !cs_bit_q) else $error("g");
  AST_RX: assert property (cs_req && !pg |=> cs_bit_q == $past(rx_cs_bit)) else $error("rx");
  AST_CH: assert property (ch |=> !cs_bit_q) else $error("ch");
  AST_ACC: assert property (reg_addr == 8'h22 |-> reg_rdata[7:6] == 2'h0) else $error("acc");
endmodule // stxcs_props

/* bench/stxcs_fb.sv */
// Purpose: frame builder stand-in
// Assumes: one request a cycle while busy
// Notes: recovered bit random; inverted when idle
`timescale 1ns/10ps
module stxcs_fb (input wire logic clk_sys, go, output logic cs_req = 0, cs_subframe = 0,
  rx_cs_bit = 0, busy = 0, output logic [7:0] cs_index = 0);
  always @(posedge go) begin
    busy = 1;
    for (int i = 0; i < 384; i++) begin
      @(posedge clk_sys);
      #1 {cs_req, cs_index, cs_subframe, rx_cs_bit} = {1'b1, 8'(i / 2), i[0], 1'($urandom)};
    end
    @(posedge clk_sys);
    #1 {cs_req, rx_cs_bit, busy} = {1'b0, ~rx_cs_bit, 1'b0};
  end
endmodule // stxcs_fb

/* bench/stxcs_bank_tb.sv */
// Purpose: self-checking bench for the status bank
// Assumes: registers reached through the index port
// Notes: a queue pairs requests with answers
`timescale 1ns/10ps
module stxcs_bank_tb;
  logic clk_sys = 0, reset = 1, reg_wr = 0, ovw = 0, go = 0, rxb, req, sf, busy, bq, val;
  logic [7:0] addr = 8'h1F, wd = 8'h00, low = 8'h00, rd, idx;
  logic [1:0] src = 0;
  logic [7:0] m [4] = '{8'h00, 8'h00, 8'h31, 8'h0B};
  logic [9:0] q [$];
  logic [9:0] e;
  int fail_count = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  stxcs_bank uut (.clk_sys, .reset, .reg_wr, .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd),
    .transmit_source_select(src), .status_overwrite_bit(ovw), .cs_low_bits(low), .cs_req(req),
    .cs_index(idx), .cs_subframe(sf), .rx_cs_bit(rxb), .cs_bit_q(bq), .cs_valid_q(val));
  stxcs_fb fb (.clk_sys, .go, .cs_req(req), .cs_subframe(sf), .rx_cs_bit(rxb), .busy, .cs_index(idx));
  function automatic logic xb(logic [7:0] i, logic s, logic r);
    logic [39:0] c;
    c = {m[3], 2'h0, m[2][5:0], m[1][7:6] & {2{s}}, m[1][5:4] & {2{!s}}, m[1][3:0], m[0], low};
    return (src == 2'h0 && !ovw) ? r : (i < 40 ? c[i] : 1'b0);
  endfunction
  task automatic cmp(logic [7:0] g, x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_bit(logic g, x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t status bit got %b exp %b", $time, g, x);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    @(posedge clk_sys);
    #1 {addr, wd, reg_wr} = {a, d, 1'b1};
    @(posedge clk_sys);
    #1 reg_wr = 0;
    if (a[7:2] == 6'h08) m[a[1:0]] = a == 8'h22 ? d & 8'h3F : d;
  endtask
  task automatic rall();
    for (int a = 8'h1F; a < 8'h25; a++) begin
      @(posedge clk_sys);
      #1 addr = 8'(a);
      #1 cmp(rd, addr[7:2] == 6'h08 ? m[addr[1:0]] : 8'h00);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) if (req && !reset) q.push_back({idx, sf, rxb});
  always @(negedge clk_sys) if (val && q.size() > 0) begin
    e = q.pop_front();
    cmp_bit(bq, xb(e[9:2], e[1], e[0]));
  end
  initial begin
    void'($urandom(97467));
    repeat (12) @(posedge clk_sys);
    #1 reset = 0;
    rall();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      #1 low = 8'($urandom);
      for (int a = 8'h1F; a < 8'h25; a++) repeat (2) wr(8'(a), 8'($urandom));
      rall();
      @(posedge clk_sys);
      #1 {src, ovw} = {k[1], 1'b0, k[0]};
      go = 1;
      @(posedge clk_sys);
      #1 go = 0;
      wait (!busy);
      repeat (2) @(posedge clk_sys);
    end
    cmp(8'(q.size()), 8'h00);
    report_and_stop();
  end
  initial begin
    #200000 fail_count++;
    report_and_stop();
  end
endmodule // stxcs_bank_tb
bind stxcs_bank stxcs_props u_props (.*);
